// ==== cmrc_top.sv ====
// CPU module reset controller: sources, combination, chip reset and boot load
// How it works
// (R1) Power-up produces a local module reset
// (R2) Backplane reset line fully initializes module
// (R3) Any node or panel may drive backplane reset
// (R4) Node reset bit resets this module only
// (R5) Serial port resets processor chip alone
// (R6) After chip reset: load ROM, PC zero, run
// (R7) Cause flag tells node from system reset
// (R8) Sources merge, assert async, release synchronously
`timescale 1ns/1ps
module cmrc_top (
	// Clock and power-on reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Reset requests from outside the clock domain
	input  wire logic                            sys_reset_in,
	input  wire logic                            panel_reset_line,
	// Node reset bit from the node control register (same clock)
	input  wire logic                            node_reset_bit,
	// Chip reset request from the serial I/O port (same clock)
	input  wire logic                            sio_chip_reset,
	// Backplane reset driven out on behalf of the panel
	output logic                                 sys_reset_out,
	// Module-wide reset, active low
	output logic                                 module_rst_n,
	// Processor chip reset, active low
	output logic                                 chip_rst_n,
	// Boot serial ROM read port
	output logic [cmrc_pkg::ROM_ADDR_W-1:0]      rom_addr,
	input  wire logic [cmrc_pkg::ROM_DATA_W-1:0] rom_data,
	// Internal cache write port
	output logic                                 cache_we,
	output logic [cmrc_pkg::ROM_ADDR_W-1:0]      cache_addr,
	output logic [cmrc_pkg::ROM_DATA_W-1:0]      cache_data,
	// Execution start
	output logic [31:0]                          pc,
	output logic                                 run,
	// Reset cause, readable by software
	output logic                                 reset_cause_flag
);
	// Local widths, so that counters and their end points match bit for bit
	localparam int                            PW        = cmrc_pkg::POR_CNT_W;
	localparam int                            AW        = cmrc_pkg::ROM_ADDR_W;
	localparam int                            DW        = cmrc_pkg::ROM_DATA_W;
	// Last count of the power-on stretch
	localparam logic [PW-1:0]                 POR_LAST  = PW'(cmrc_pkg::POR_CYCLES);
	// Step of the power-on counter
	localparam logic [PW-1:0]                 POR_STEP  = PW'(1);
	// Last word of the boot image
	localparam logic [AW-1:0]                 ROM_LAST  = AW'(cmrc_pkg::ROM_WORDS - 1);
	// Step of the boot address counter
	localparam logic [AW-1:0]                 ADDR_STEP = AW'(1);

	// Power pin after its own two flip-flops
	logic                                     por_rst_n;
	// Backplane reset line synchronizer
	logic                                     sys_s1_q;
	logic                                     sys_s1_d;
	logic                                     sys_s2_q;
	logic                                     sys_s2_d;
	// Panel reset line synchronizer
	logic                                     pan_s1_q;
	logic                                     pan_s1_d;
	logic                                     pan_s2_q;
	logic                                     pan_s2_d;
	// Power-on stretch counter
	logic [PW-1:0]                            por_cnt_q;
	logic [PW-1:0]                            por_cnt_d;
	// Stretch still running
	logic                                     por_busy;
	// Registered module reset request, so the async reset sees no glitch
	logic                                     mod_req_q;
	logic                                     mod_req_d;
	// Merged module reset request, active low
	logic                                     mod_req_n;
	// Registered serial port chip reset request
	logic                                     sio_q;
	logic                                     sio_d;
	// Merged chip reset request, active low
	logic                                     chip_req_n;
	// Reset cause, survives module and chip resets
	logic                                     cause_q;
	logic                                     cause_d;
	// Boot loader state
	cmrc_pkg::cmrc_boot_t                     state_q;
	cmrc_pkg::cmrc_boot_t                     state_d;
	// Boot ROM read address
	logic [AW-1:0]                            addr_q;
	logic [AW-1:0]                            addr_d;
	// Cache write port registers
	logic                                     cache_we_q;
	logic                                     cache_we_d;
	logic [AW-1:0]                            cache_addr_q;
	logic [AW-1:0]                            cache_addr_d;
	logic [DW-1:0]                            cache_data_q;
	logic [DW-1:0]                            cache_data_d;
	// Execution start registers
	logic [31:0]                              pc_q;
	logic [31:0]                              pc_d;
	logic                                     run_q;
	logic                                     run_d;

	// Power pin: asserts at once, releases two clocks later
	cmrc_sync por_sync_u (
		.clk       (clk),
		.req_n     (rst_n),
		.rst_out_n (por_rst_n)
	); // R1

	// Input synchronizers: next values
	always_comb begin
		sys_s1_d = sys_reset_in;
		sys_s2_d = sys_s1_q;
		pan_s1_d = panel_reset_line;
		pan_s2_d = pan_s1_q;
	end

	// Input synchronizers: only the second stage is read by logic
	always_ff @(posedge clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			sys_s1_q <= 1'b0;
			sys_s2_q <= 1'b0;
			pan_s1_q <= 1'b0;
			pan_s2_q <= 1'b0;
		end else begin
			sys_s1_q <= sys_s1_d;
			sys_s2_q <= sys_s2_d;
			pan_s1_q <= pan_s1_d;
			pan_s2_q <= pan_s2_d;
		end
	end

	// Panel keyswitch is passed on to the backplane line for all nodes
	assign sys_reset_out = pan_s2_q; // R3

	// Power-on stretch: holds the module in reset while supplies settle
	assign por_busy = (por_cnt_q != POR_LAST); // R1

	// Power-on stretch: count up once, then hold at the end point
	always_comb begin
		por_cnt_d = por_cnt_q;
		if (por_busy) begin
			por_cnt_d = por_cnt_q + POR_STEP;
		end
	end

	// Power-on stretch register
	always_ff @(posedge clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			por_cnt_q <= '0;
		end else begin
			por_cnt_q <= por_cnt_d;
		end
	end

	// Module request: power-up, backplane line or node bit
	always_comb begin
		mod_req_d = por_busy | sys_s2_q | node_reset_bit; // R2 R4 R8
	end

	// Module request register; starts asserted so reset is held from power-up
	always_ff @(posedge clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			mod_req_q <= 1'b1;
		end else begin
			mod_req_q <= mod_req_d;
		end
	end

	// Only flip-flop outputs enter the async reset, never a live input
	assign mod_req_n = por_rst_n & ~mod_req_q; // R8

	// Module reset: async assertion, release two clocks later
	cmrc_sync mod_sync_u (
		.clk       (clk),
		.req_n     (mod_req_n),
		.rst_out_n (module_rst_n)
	); // R8

	// Reset cause: backplane reset outranks a node reset in the same cycle
	always_comb begin
		cause_d = cause_q;
		if (sys_s2_q) begin
			cause_d = cmrc_pkg::CAUSE_SYSTEM; // R7
		end else if (node_reset_bit) begin
			cause_d = cmrc_pkg::CAUSE_NODE; // R7
		end
	end

	// Reset cause register; cleared by power-up only, so software can read it
	always_ff @(posedge clk or negedge por_rst_n) begin
		if (!por_rst_n) begin
			cause_q <= cmrc_pkg::CAUSE_SYSTEM;
		end else begin
			cause_q <= cause_d;
		end
	end

	// Reset cause output
	assign reset_cause_flag = cause_q; // R7

	// Serial port chip reset: next value
	always_comb begin
		sio_d = sio_chip_reset;
	end

	// Serial port request register, cleared with the module
	always_ff @(posedge clk or negedge module_rst_n) begin
		if (!module_rst_n) begin
			sio_q <= 1'b0;
		end else begin
			sio_q <= sio_d;
		end
	end

	// Chip reset follows the module reset, or the serial port alone
	assign chip_req_n = module_rst_n & ~sio_q; // R5

	// Chip reset: the serial port path leaves module_rst_n untouched
	cmrc_sync chip_sync_u (
		.clk       (clk),
		.req_n     (chip_req_n),
		.rst_out_n (chip_rst_n)
	); // R5

	// Boot loader: copy the ROM word by word, then start at the reset PC
	always_comb begin
		state_d      = state_q;
		addr_d       = addr_q;
		cache_we_d   = 1'b0;
		cache_addr_d = cache_addr_q;
		cache_data_d = cache_data_q;
		pc_d         = pc_q;
		run_d        = run_q;
		case (state_q)
			cmrc_pkg::CMRC_IDLE: begin
				// First cycle after chip reset release
				addr_d  = '0;
				state_d = cmrc_pkg::CMRC_LOAD;
			end
			cmrc_pkg::CMRC_LOAD: begin
				// ROM is read combinationally, so the word is ready now
				cache_we_d   = 1'b1; // R6
				cache_addr_d = addr_q;
				cache_data_d = rom_data;
				if (addr_q == ROM_LAST) begin
					pc_d    = cmrc_pkg::PC_START; // R6
					run_d   = 1'b1;
					state_d = cmrc_pkg::CMRC_RUN;
				end else begin
					addr_d = addr_q + ADDR_STEP;
				end
			end
			cmrc_pkg::CMRC_RUN: begin
				// Executing; only a chip reset brings the loader back
				run_d = 1'b1;
			end
			default: begin
				state_d = cmrc_pkg::CMRC_IDLE;
			end
		endcase
	end

	// Boot loader registers, cleared by the chip reset
	always_ff @(posedge clk or negedge chip_rst_n) begin
		if (!chip_rst_n) begin
			state_q      <= cmrc_pkg::CMRC_IDLE;
			addr_q       <= '0;
			cache_we_q   <= 1'b0;
			cache_addr_q <= '0;
			cache_data_q <= '0;
			pc_q         <= cmrc_pkg::PC_START;
			run_q        <= 1'b0;
		end else begin
			state_q      <= state_d;
			addr_q       <= addr_d;
			cache_we_q   <= cache_we_d;
			cache_addr_q <= cache_addr_d;
			cache_data_q <= cache_data_d;
			pc_q         <= pc_d;
			run_q        <= run_d;
		end
	end

	// Boot ROM and cache ports, all driven from flip-flops
	assign rom_addr   = addr_q;
	assign cache_we   = cache_we_q;
	assign cache_addr = cache_addr_q;
	assign cache_data = cache_data_q;
	// Execution start
	assign pc         = pc_q; // R6
	assign run        = run_q; // R6
endmodule

// ==== cmrc_pkg.sv ====
// Package of constants for the CPU module reset controller
package cmrc_pkg;
	// Power-on reset stretch, in ns, and its cycle count at 50 MHz
	localparam int POR_TIME_NS    = 2000;
	localparam int CLK_PERIOD_NS  = 20;
	localparam int POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_CNT_W      = 8;
	// Boot ROM image size, in words
	localparam int ROM_WORDS      = 16;
	localparam int ROM_ADDR_W     = 4;
	localparam int ROM_DATA_W     = 32;
	// Program counter start value after boot load
	localparam logic [31:0] PC_START = 32'h0000_0000;
	// Reset cause encoding
	localparam logic CAUSE_NODE   = 1'b1;
	localparam logic CAUSE_SYSTEM = 1'b0;
	// Boot loader states
	typedef enum logic [1:0] {CMRC_IDLE, CMRC_LOAD, CMRC_RUN} cmrc_boot_t;
endpackage

// ==== cmrc_sync.sv ====
// Reset synchronizer: asserts asynchronously, releases on the clock
`timescale 1ns/1ps
module cmrc_sync (
	// Clock and asynchronous reset request, active low
	input  wire logic clk,
	input  wire logic req_n,
	// Synchronized reset, active low
	output logic      rst_out_n
);
	logic s1_q;   // First stage, read only by second stage
	logic s2_q;   // Second stage

	// Two-stage release keeps deassertion clear of metastability
	always_ff @(posedge clk or negedge req_n) begin
		if (!req_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= 1'b1;
			s2_q <= s1_q;
		end
	end

	assign rst_out_n = s2_q;
endmodule

// ==== cmrc_rom.sv ====
// Boot ROM stand-in whose words carry their own address
`timescale 1ns/1ps
module cmrc_rom (input wire logic [3:0] a, output logic [31:0] d);
	assign d = {28'h5a5a5a5, a};
endmodule

// Backplane reset line: driven by any other node or by this module for the panel
module cmrc_backplane (
	// Drivers of the shared line
	input  wire logic other_node_drive,
	input  wire logic panel_drive,
	// Shared line as every node sees it
	output logic      line
);
	assign line = other_node_drive | panel_drive;
endmodule

// ==== cmrc_top_assertions.sv ====
// Checker for reset sources, chip reset and boot start
`timescale 1ns/1ps
module cmrc_top_assertions (input wire logic clk, rst_n, sys_reset_in, node_reset_bit,
	sio_chip_reset, module_rst_n, chip_rst_n, run, reset_cause_flag, input wire logic [31:0] pc);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sys_init_a: assert property (sys_reset_in |-> ##[0:3] !module_rst_n)
		else $error("sys");
	node_init_a: assert property (node_reset_bit |-> ##[0:3] !module_rst_n)
		else $error("nd");
	chip_rst_a: assert property (sio_chip_reset |-> ##[0:3] !chip_rst_n)
		else $error("chip");
	chip_only_a: assert property (sio_chip_reset && module_rst_n |=> module_rst_n)
		else $error("m");
	run_pc_a: assert property ($rose(run) |-> pc == cmrc_pkg::PC_START)
		else $error("pc");
	sys_cause_a: assert property (sys_reset_in |-> ##[1:20] !reset_cause_flag)
		else $error("c");
	node_cause_a: assert property (node_reset_bit && !sys_reset_in |=> reset_cause_flag)
		else $error("node cause");
	chip_order_a: assert property (!module_rst_n |-> !chip_rst_n)
		else $error("chip order");
	boot_run_c: cover property ($rose(run));
	node_cause_c: cover property ($rose(reset_cause_flag));
	chip_only_c: cover property (!chip_rst_n && module_rst_n);
	sys_line_c: cover property (sys_reset_in);
endmodule
bind cmrc_top cmrc_top_assertions chk_u (.*);

// ==== cmrc_top_tb.sv ====
// Bench firing random reset sources and checking each boot
`timescale 1ns/1ps
module cmrc_top_tb;
	logic clk = 0, rst_n = 0, sys_reset_in, panel_reset_line = 0, node_reset_bit = 0;
	logic sio_chip_reset = 0, other_node_drive = 0;
	logic sys_reset_out, module_rst_n, chip_rst_n, cache_we, run, reset_cause_flag;
	logic [3:0] rom_addr, cache_addr;
	logic [31:0] rom_data, cache_data, pc;
	int fail_count = 0, checked = 0, seed = 74388, k, s, exp_c = 0, exp_a = 0;
	int exp_q[$] = '{0};
	cmrc_rom rom_u (.a(rom_addr), .d(rom_data));
	cmrc_backplane bp_u (.other_node_drive(other_node_drive), .panel_drive(sys_reset_out),
		.line(sys_reset_in));
	cmrc_top dut_u (.clk(clk), .rst_n(rst_n), .sys_reset_in(sys_reset_in),
		.panel_reset_line(panel_reset_line), .node_reset_bit(node_reset_bit),
		.sio_chip_reset(sio_chip_reset), .sys_reset_out(sys_reset_out),
		.module_rst_n(module_rst_n), .chip_rst_n(chip_rst_n), .rom_addr(rom_addr),
		.rom_data(rom_data), .cache_we(cache_we), .cache_addr(cache_addr),
		.cache_data(cache_data), .pc(pc), .run(run), .reset_cause_flag(reset_cause_flag));
	initial forever #10 clk = ~clk;
	task chk(string n, logic [31:0] e, logic [31:0] v);
		checked++;
		if (e !== v) begin fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end
	endtask
	task print_verdict;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("*** PASS ***"); else $display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge clk) if (cache_we === 1'b1) begin
		chk("cache addr", exp_a, cache_addr);
		chk("cache data", {28'h5a5a5a5, exp_a[3:0]}, cache_data);
		exp_a++;
	end
	initial begin
		repeat (4) @(posedge clk);
		#2 rst_n = 1;
		for (int i = 0; i < 12; i++) begin
			for (k = 0; run !== 1'b1; k++) begin
				if (k > 900) begin fail_count++; print_verdict; end
				@(posedge clk);
			end
			#2 chk("pc", cmrc_pkg::PC_START, pc);
			chk("words", cmrc_pkg::ROM_WORDS, exp_a);
			chk("cause", exp_q.pop_front(), reset_cause_flag);
			exp_a = 0;
			s = $unsigned($random(seed)) % 4;
			if (s == 1) exp_c = cmrc_pkg::CAUSE_NODE;
			else if (s != 2) exp_c = cmrc_pkg::CAUSE_SYSTEM;
			exp_q.push_back(exp_c);
			{panel_reset_line, node_reset_bit, other_node_drive, sio_chip_reset} =
				(s == 0) ? 4'h2 : (s == 1) ? 4'h4 : (s == 2) ? 4'h1 : 4'h8;
			@(posedge clk) #2 {panel_reset_line, node_reset_bit, other_node_drive, sio_chip_reset} = 4'h0;
			for (k = 0; run !== 1'b0 && k < 20; k++) @(posedge clk);
			#2 chk("run drop", 0, run);
			chk("module reset", (s == 2) ? 1 : 0, module_rst_n);
			chk("chip reset", 0, chip_rst_n);
		end
		print_verdict;
	end
endmodule
